//--- lbus_mem.sv
// far-side memory model: reset pattern, read answers, churn when released
module lbus_mem
  import lbus_pkg::*;
(
  input  wire logic        mclk,    // bus clock
  input  wire logic        rst_b,   // reset, active low
  input  wire logic        den_n,   // transceiver enable
  input  wire logic        dir,     // transfer direction
  input  wire logic [15:0] rd_val,  // read answer
  input  wire logic [15:0] cfg_val, // pattern shown in reset
  output logic      [15:0] pins     // value driven to the pins
);
  logic [15:0] last_ff; // last driven value
  logic        cfg_ff;  // pattern still shown
  // pattern stays until the first edge after release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) cfg_ff <= 1'h1;
    else cfg_ff <= 1'h0;
  end
  // remember what was driven so a released bus never holds it
  always_ff @(posedge mclk) last_ff <= pins;
  // drive pattern, read data, or the inverse of the last value
  always_comb begin
    if (cfg_ff) pins = cfg_val;
    else if (!den_n && !dir) pins = rd_val;
    else pins = ~last_ff;
  end
endmodule

//--- lbus_pins.sv
// local bus master pin logic: bus cycle sequencing and pin drivers
// Contract
// - address pins lead muxed bus half clock (here both load on the edge that enters t1)
// - address pins float in hold or reset
// - low muxed pins: address t1, data t2-t4
// - inactive byte write floats that data byte
// - muxed pins float in hold and reset
// - muxed pins loaded into config at reset
// - byte-wide high address valid t1-t4
// - strobe pulses with address, floats only test
// - async ready high means ready, else sync
// - ube and a0 encode transfer type
// - ube driven t1 through t3 and waits
// - strap sampled at reset release gates address
// - low strap forces status pins normal
// - byte-wide high address ignores disable bit
// - first clock out full, save or float
// - second clock out likewise selected
// - transceiver enable in cycles, drops on direction
// - dma requests synchronized, level sensitive
// - direction high send, low receive, floats
//
// Implementation choices: strobed register access and the address map.
module lbus_pins
  import lbus_pkg::*;
#(
  parameter int BYTE_WIDE = 1            // 1 byte-wide variant, 0 word-wide
)
(
  input  wire logic                mclk,                 // internal clock
  input  wire logic                rst_b,                // async reset, active low
  input  wire bus_req_t            req,                  // pending request
  input  wire logic                req_valid,            // request waiting
  output logic                     req_done_ff,          // cycle finished pulse
  output logic [15:0]              rdata_ff,             // read data
  input  wire logic                hold_grant,           // bus hold granted
  input  wire logic                all_float_test_mode,  // pins with an enable float, except the clocks
  input  wire logic [1:0]          power_save_ctl,       // clock out select
  input  wire logic [PS_DIV_W-1:0] ps_divisor,           // power-save halves
  input  wire logic                async_ready_in,       // async ready pin
  input  wire logic                sync_ready_in,        // sync ready pin
  input  wire logic [NUM_DRQ-1:0]  dma_request_in,       // dma request pins
  output logic [NUM_DRQ-1:0]       dma_req_sync_ff,      // synchronized requests
  input  wire logic                addr_phase_strap_n,   // strap level
  output logic                     status_normal_ff,     // status pins forced normal
  output logic [CFG_W-1:0]         reset_cfg_ff,         // reset configuration
  output logic [ADDR_W-1:0]        addr_out_ff,          // dedicated address
  output logic                     addr_out_oe_ff,       // its enable
  input  wire logic [LOW_W-1:0]    muxed_addr_data_low_i,// low pins in
  output logic [LOW_W-1:0]         muxed_addr_data_low_o_ff, // low pins out
  output logic                     muxed_addr_data_low_oe_ff, // low enable
  input  wire logic [HIGH_W-1:0]   muxed_addr_data_high_i,   // high pins in
  output logic [HIGH_W-1:0]        muxed_addr_data_high_o_ff,// high pins out
  output logic                     muxed_addr_data_high_oe_ff,// high enable
  output logic                     addr_strobe_ff,       // address strobe
  output logic                     addr_strobe_oe_ff,    // strobe enable
  output logic                     upper_byte_enable_n_ff, // ube
  output logic                     upper_byte_enable_oe_ff,// ube enable
  output logic                     low_byte_write_n_ff,  // low write strobe
  output logic                     high_byte_write_n_ff, // high write strobe
  output logic                     transceiver_enable_n_ff, // den
  output logic                     transceiver_enable_oe_ff,// den enable
  output logic                     transfer_direction_ff,  // dt/r
  output logic                     transfer_direction_oe_ff,// dt/r enable
  output logic                     sys_clock_out_first_ff,  // first clock
  output logic                     sys_clock_out_first_oe_ff,// its enable
  output logic                     sys_clock_out_second_ff, // second clock
  output logic                     sys_clock_out_second_oe_ff // its enable
);

  // ************************************************************
  // functions
  // ************************************************************
  // true when a three-stage sample settled high
  function automatic logic settled_high(input logic [2:0] s);
    settled_high = s[1] & s[2];
  endfunction

  // true when a three-stage sample settled low
  function automatic logic settled_low(input logic [2:0] s);
    settled_low = ~s[1] & ~s[2];
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  bus_state_t          state_ff;        // bus cycle state
  bus_state_t          nxt_state;       // next state
  bus_req_t            cur_ff;          // request in flight
  logic [2:0]          async_ready_in_s_ff;       // async ready sampler
  logic                async_ready_in_lvl_ff;     // filtered async ready
  logic [2:0]          drq_s_ff [NUM_DRQ]; // dma samplers
  logic [2:0]          strap_s_ff;      // strap sampler
  logic                strap_lvl_ff;    // filtered strap
  logic                cfg_done_ff;     // strap and config captured
  logic                strap_n_ff;      // captured strap
  logic [PS_DIV_W-1:0] ps_cnt_ff;       // power-save divider
  logic                ps_clk_ff;       // divided clock
  logic                half_ff;         // half-period phase of output clock
  logic                last_dir_ff;     // direction of last cycle

  // ************************************************************
  // decode
  // ************************************************************
  wire logic ready_now;                 // selected ready
  wire logic addr_phase_on;             // muxed address phase shown
  wire logic pins_float;                // hold or test-mode float
  wire logic in_data_phase;             // t2, t3, tw, t4
  wire logic bus_active;                // any cycle state
  wire logic start_cycle;               // t1 taken
  wire logic dir_change;                // direction flips at t1

  // async high always ready, else sync ready decides
  assign ready_now     = async_ready_in_lvl_ff | sync_ready_in;
  // low strap forces address; high follows the region disable bit
  assign addr_phase_on = ~strap_n_ff | ~(req.region_hit & req.da_bit);
  assign pins_float    = hold_grant | all_float_test_mode;
  assign in_data_phase = (state_ff == ST_T2) | (state_ff == ST_T3) |
                         (state_ff == ST_TW) | (state_ff == ST_T4);
  assign bus_active    = (state_ff != ST_IDLE);
  assign start_cycle   = (state_ff == ST_IDLE) & req_valid & ~hold_grant & cfg_done_ff;
  assign dir_change    = start_cycle & (req.write != last_dir_ff);

  // ************************************************************
  // bus cycle sequence
  // ************************************************************
  // t1, t2, t3, waits while not ready, then t4
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (start_cycle) nxt_state = ST_T1;
      ST_T1:   nxt_state = ST_T2;
      ST_T2:   nxt_state = ST_T3;
      ST_T3:   nxt_state = ready_now ? ST_T4 : ST_TW;
      ST_TW:   nxt_state = ready_now ? ST_T4 : ST_TW;
      ST_T4:   nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state and request capture
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff    <= ST_IDLE;
      cur_ff      <= '0;
      last_dir_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      if (start_cycle) begin
        cur_ff      <= req;
        last_dir_ff <= req.write;
      end
    end
  end

  // completion pulse and read data capture
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_done_ff <= 1'h0;
      rdata_ff    <= 16'h0000;
    end else begin
      req_done_ff <= (state_ff == ST_T4);
      if (state_ff == ST_T4 && !cur_ff.write)
        rdata_ff <= {muxed_addr_data_high_i, muxed_addr_data_low_i};
    end
  end

  // ************************************************************
  // input samplers
  // ************************************************************
  // three-stage samplers; stage one feeds stage two only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      async_ready_in_s_ff   <= SYNC_RESET;
      async_ready_in_lvl_ff <= 1'h0;
      for (int i = 0; i < NUM_DRQ; i++) drq_s_ff[i] <= SYNC_RESET;
      dma_req_sync_ff <= '0;
    end else begin
      async_ready_in_s_ff  <= {async_ready_in_s_ff[1:0], async_ready_in};
      // rise and fall both accepted only once settled in stages two and three
      if (settled_high(async_ready_in_s_ff)) async_ready_in_lvl_ff <= 1'h1;
      else if (settled_low(async_ready_in_s_ff)) async_ready_in_lvl_ff <= 1'h0;
      for (int i = 0; i < NUM_DRQ; i++) begin
        drq_s_ff[i] <= {drq_s_ff[i][1:0], dma_request_in[i]};
        // level only, follows the pin, nothing latched
        if (settled_high(drq_s_ff[i])) dma_req_sync_ff[i] <= 1'h1;
        else if (settled_low(drq_s_ff[i])) dma_req_sync_ff[i] <= 1'h0;
      end
    end
  end

  // strap sampler has no reset: it must settle while reset is held
  always_ff @(posedge mclk) begin
    strap_s_ff <= {strap_s_ff[1:0], addr_phase_strap_n};
    if (settled_high(strap_s_ff)) strap_lvl_ff <= 1'h1;
    else if (settled_low(strap_s_ff)) strap_lvl_ff <= 1'h0;
  end

  // ************************************************************
  // reset-release capture
  // ************************************************************
  // first edge after release: strap and muxed pins captured
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_done_ff      <= 1'h0;
      strap_n_ff       <= STRAP_RESET;
      status_normal_ff <= 1'h0;
      reset_cfg_ff     <= CFG_RESET;
    end else if (!cfg_done_ff) begin
      cfg_done_ff      <= 1'h1;
      strap_n_ff       <= strap_lvl_ff;
      status_normal_ff <= ~strap_lvl_ff;
      reset_cfg_ff     <= {muxed_addr_data_high_i, muxed_addr_data_low_i};
    end
  end

  // ************************************************************
  // clock outputs
  // ************************************************************
  // power-save divider and half-period phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ps_cnt_ff <= '0;
      ps_clk_ff <= 1'h0;
      half_ff   <= 1'h0;
    end else begin
      half_ff <= ~half_ff;
      if (ps_cnt_ff >= ps_divisor) begin
        ps_cnt_ff <= '0;
        ps_clk_ff <= ~ps_clk_ff;
      end else begin
        ps_cnt_ff <= ps_cnt_ff + 1'b1;
      end
    end
  end

  // clock pins keep running through hold; reset holds them low and driven
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sys_clock_out_first_ff     <= 1'h0;
      sys_clock_out_first_oe_ff  <= 1'h1;
      sys_clock_out_second_ff    <= 1'h0;
      sys_clock_out_second_oe_ff <= 1'h1;
    end else begin
      sys_clock_out_first_ff     <= (power_save_ctl == CLK_SEL_SAVE) ? ps_clk_ff : ~half_ff;
      sys_clock_out_first_oe_ff  <= (power_save_ctl != CLK_SEL_FLOAT);
      sys_clock_out_second_ff    <= (power_save_ctl == CLK_SEL_SAVE) ? ps_clk_ff : ~half_ff;
      sys_clock_out_second_oe_ff <= (power_save_ctl != CLK_SEL_FLOAT);
    end
  end

  // ************************************************************
  // address and control pins
  // ************************************************************
  // dedicated address set with the request, on the same edge that enters t1
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_out_ff    <= '0;
      addr_out_oe_ff <= 1'h0;
    end else begin
      if (start_cycle) addr_out_ff <= req.addr;
      addr_out_oe_ff <= ~pins_float;
    end
  end

  // strobe, ube, write strobes, den, dt/r
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_strobe_ff           <= 1'h0;
      addr_strobe_oe_ff        <= 1'h1;
      upper_byte_enable_n_ff   <= 1'h1;
      upper_byte_enable_oe_ff  <= 1'h0;
      low_byte_write_n_ff      <= 1'h1;
      high_byte_write_n_ff     <= 1'h1;
      transceiver_enable_n_ff  <= 1'h1;
      transceiver_enable_oe_ff <= 1'h0;
      transfer_direction_ff    <= 1'h0;
      transfer_direction_oe_ff <= 1'h0;
    end else begin
      // pulse during t1 only; strobe floats only in the test mode
      addr_strobe_ff    <= start_cycle;
      addr_strobe_oe_ff <= ~all_float_test_mode;
      // ube during t1 to t3 and waits
      if (start_cycle)
        upper_byte_enable_n_ff <= req.xfer[ENC_UBE_POS];
      else if (nxt_state == ST_T4 || nxt_state == ST_IDLE)
        upper_byte_enable_n_ff <= 1'h1;
      upper_byte_enable_oe_ff <= ~pins_float;
      // byte write strobes during t2, t3 and waits of writes
      low_byte_write_n_ff  <= ~((nxt_state == ST_T2 || nxt_state == ST_T3 || nxt_state == ST_TW) &
                               cur_ff.write & ~cur_ff.xfer[ENC_A0_POS]);
      high_byte_write_n_ff <= ~((nxt_state == ST_T2 || nxt_state == ST_T3 || nxt_state == ST_TW) &
                               cur_ff.write & ~cur_ff.xfer[ENC_UBE_POS]);
      // direction: high send, low receive
      if (start_cycle) transfer_direction_ff <= req.write;
      transfer_direction_oe_ff <= ~pins_float;
      // enable in memory, io, inta; dropped on a direction flip
      if (dir_change)
        transceiver_enable_n_ff <= 1'h1;
      else
        transceiver_enable_n_ff <= ~((nxt_state == ST_T2 || nxt_state == ST_T3 ||
                                      nxt_state == ST_TW || nxt_state == ST_T4) &
                                     (cur_ff.kind != KIND_IDLE));
      transceiver_enable_oe_ff <= ~pins_float;
    end
  end

  // ************************************************************
  // multiplexed pins
  // ************************************************************
  // low byte: address in t1 then data; floats in hold
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      muxed_addr_data_low_o_ff   <= '0;
      muxed_addr_data_low_oe_ff  <= 1'h0;
      muxed_addr_data_high_o_ff  <= '0;
      muxed_addr_data_high_oe_ff <= 1'h0;
    end else if (pins_float) begin
      muxed_addr_data_low_oe_ff  <= 1'h0;
      muxed_addr_data_high_oe_ff <= 1'h0;
    end else if (nxt_state == ST_T1) begin
      // muxed bit zero carries the encoded a0 for refresh detection
      muxed_addr_data_low_o_ff  <= {req.addr[LOW_W-1:1], req.xfer[ENC_A0_POS]};
      muxed_addr_data_low_oe_ff <= addr_phase_on;
      muxed_addr_data_high_o_ff <= req.addr[LOW_W+HIGH_W-1:LOW_W];
      // byte-wide high pins always address
      muxed_addr_data_high_oe_ff <= (BYTE_WIDE != 0) | addr_phase_on;
    end else if (in_data_phase || nxt_state == ST_T2) begin
      muxed_addr_data_low_o_ff  <= cur_ff.wdata[LOW_W-1:0];
      muxed_addr_data_low_oe_ff <= ~low_byte_write_n_ff | (nxt_state == ST_T2 &&
                                   cur_ff.write && !cur_ff.xfer[ENC_A0_POS]);
      if (BYTE_WIDE != 0) begin
        muxed_addr_data_high_oe_ff <= 1'h1;
      end else begin
        muxed_addr_data_high_o_ff  <= cur_ff.wdata[15:8];
        muxed_addr_data_high_oe_ff <= ~high_byte_write_n_ff | (nxt_state == ST_T2 &&
                                      cur_ff.write && !cur_ff.xfer[ENC_UBE_POS]);
      end
      if (nxt_state == ST_IDLE) begin
        muxed_addr_data_low_oe_ff  <= 1'h0;
        muxed_addr_data_high_oe_ff <= 1'h0;
      end
    end else begin
      muxed_addr_data_low_oe_ff  <= 1'h0;
      muxed_addr_data_high_oe_ff <= 1'h0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  seq_order_a: assert property (state_ff == ST_T1 |=> state_ff == ST_T2 ##1 state_ff == ST_T3)
    else $error("t1 not followed by t2 t3");
  wait_ready_a: assert property (state_ff == ST_T3 && !ready_now |=> state_ff == ST_TW)
    else $error("no wait state while not ready");
  async_ready_in_ready_a: assert property (state_ff == ST_TW && async_ready_in_lvl_ff |=> state_ff == ST_T4)
    else $error("async ready ignored");
  strobe_t1_a: assert property ($rose(addr_strobe_ff) |-> state_ff == ST_T1)
    else $error("strobe outside t1");
  addr_lead_a: assert property (start_cycle |=> addr_out_ff == $past(req.addr))
    else $error("address not early");
  hold_float_a: assert property (hold_grant |=> !addr_out_oe_ff && !muxed_addr_data_low_oe_ff)
    else $error("pins driven in hold");
  ube_hold_a: assert property (state_ff == ST_TW |-> upper_byte_enable_n_ff == cur_ff.xfer[ENC_UBE_POS])
    else $error("ube lost in wait");
  clk_float_a: assert property (power_save_ctl == CLK_SEL_FLOAT |=> !sys_clock_out_first_oe_ff)
    else $error("clock not floated");
  den_flip_a: assert property (dir_change |=> transceiver_enable_n_ff)
    else $error("den kept on direction change");
  dir_a: assert property (state_ff == ST_T2 |-> transfer_direction_ff == cur_ff.write)
    else $error("direction wrong");

  cov_write_c: cover property (state_ff == ST_T1 && cur_ff.write ##3 state_ff == ST_T4);
  cov_wait_c:  cover property (state_ff == ST_TW ##1 state_ff == ST_T4);
  cov_hold_c:  cover property (hold_grant && bus_active);

endmodule

//--- lbus_pkg.sv
// package for the local bus master pin interface: constants, types, states
package lbus_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int ADDR_W       = 20;                  // dedicated address width
  localparam int LOW_W        = 8;                   // low muxed byte width
  localparam int HIGH_W       = 8;                   // high byte width
  localparam int CFG_W        = 16;                  // reset configuration width
  localparam int NUM_DRQ      = 2;                   // dma request inputs
  localparam int PS_DIV_W     = 8;                   // power-save divider width

  // ************************************************************
  // clock output selection codes
  // ************************************************************
  localparam logic [1:0] CLK_SEL_FULL  = 2'h0;       // crystal frequency
  localparam logic [1:0] CLK_SEL_SAVE  = 2'h1;       // power-save frequency
  localparam logic [1:0] CLK_SEL_FLOAT = 2'h2;       // three-stated

  // ************************************************************
  // byte-enable encoding positions and values
  // ************************************************************
  localparam logic [1:0] XFER_WORD    = 2'h0;        // ube low, a0 low
  localparam logic [1:0] XFER_HIGH    = 2'h1;        // ube low, a0 high
  localparam logic [1:0] XFER_LOW     = 2'h2;        // ube high, a0 low
  localparam logic [1:0] XFER_REFRESH = 2'h3;        // both high
  localparam int         ENC_UBE_POS  = 1;           // ube bit within code
  localparam int         ENC_A0_POS   = 0;           // a0 bit within code

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [CFG_W-1:0] CFG_RESET   = 16'hFFFF; // config register reset
  localparam logic             STRAP_RESET = 1'h1;     // strap seen as floating
  localparam logic [2:0]       SYNC_RESET  = 3'h0;     // synchroniser reset

  // ************************************************************
  // cycle kinds
  // ************************************************************
  typedef enum logic [1:0] {
    KIND_MEM,
    KIND_IO,
    KIND_INTA,
    KIND_IDLE
  } cyc_kind_t;

  // ************************************************************
  // bus cycle states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_TW,
    ST_T4
  } bus_state_t;

  // ************************************************************
  // request from the core to the pin logic
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;       // full address
    logic [1:0]        xfer;       // byte-enable code
    logic              write;      // 1 send, 0 receive
    cyc_kind_t         kind;       // memory, io, inta
    logic              region_hit; // lower or upper region select active
    logic              da_bit;     // disable-address bit of that region
    logic [15:0]       wdata;      // write data
  } bus_req_t;

endpackage

//--- local_bus_master_pin_interface_bench.sv
// testbench for the local bus master pin logic
module local_bus_master_pin_interface_bench
  import lbus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic mclk = 0, rst_b = 0, req_valid = 0, hold_grant = 0, all_float_test_mode = 0;
  logic async_ready_in = 1, sync_ready_in = 0, addr_phase_strap_n = 0;
  logic [1:0] power_save_ctl = CLK_SEL_FULL, dma_request_in = 2'h0;
  logic [7:0] ps_divisor = 8'h03, muxed_addr_data_low_i, muxed_addr_data_high_i;
  bus_req_t req = '0, r;
  logic req_done_ff, status_normal_ff, addr_out_oe_ff, muxed_addr_data_low_oe_ff, muxed_addr_data_high_oe_ff;
  logic addr_strobe_ff, addr_strobe_oe_ff, upper_byte_enable_n_ff, upper_byte_enable_oe_ff, low_byte_write_n_ff;
  logic high_byte_write_n_ff, transceiver_enable_n_ff, transceiver_enable_oe_ff, transfer_direction_ff;
  logic transfer_direction_oe_ff, sys_clock_out_first_ff, sys_clock_out_first_oe_ff;
  logic sys_clock_out_second_ff, sys_clock_out_second_oe_ff;
  logic [15:0] rdata_ff, reset_cfg_ff, mem_pins, rd_val, cfg_val;
  logic [1:0] dma_req_sync_ff;
  logic [19:0] addr_out_ff;
  logic [7:0] muxed_addr_data_low_o_ff, muxed_addr_data_high_o_ff;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  logic ck; // clock pin sample
  // pins seen by the device: its own drive, else the far side
  assign muxed_addr_data_low_i = muxed_addr_data_low_oe_ff ? muxed_addr_data_low_o_ff : mem_pins[7:0];
  assign muxed_addr_data_high_i = muxed_addr_data_high_oe_ff ? muxed_addr_data_high_o_ff : mem_pins[15:8];
  lbus_pins dut_u (.mclk, .rst_b, .req, .req_valid, .req_done_ff, .rdata_ff, .hold_grant, .all_float_test_mode,
    .power_save_ctl, .ps_divisor, .async_ready_in, .sync_ready_in, .dma_request_in, .dma_req_sync_ff,
    .addr_phase_strap_n, .status_normal_ff, .reset_cfg_ff, .addr_out_ff, .addr_out_oe_ff, .muxed_addr_data_low_i,
    .muxed_addr_data_low_o_ff, .muxed_addr_data_low_oe_ff, .muxed_addr_data_high_i, .muxed_addr_data_high_o_ff,
    .muxed_addr_data_high_oe_ff, .addr_strobe_ff, .addr_strobe_oe_ff, .upper_byte_enable_n_ff,
    .upper_byte_enable_oe_ff, .low_byte_write_n_ff, .high_byte_write_n_ff, .transceiver_enable_n_ff,
    .transceiver_enable_oe_ff, .transfer_direction_ff, .transfer_direction_oe_ff, .sys_clock_out_first_ff,
    .sys_clock_out_first_oe_ff, .sys_clock_out_second_ff, .sys_clock_out_second_oe_ff);
  lbus_mem mem_u (.mclk, .rst_b, .den_n(transceiver_enable_n_ff), .dir(transfer_direction_ff), .rd_val, .cfg_val,
    .pins(mem_pins));
  // ************************************************************
  // clock, watchdog, shared tasks
  // ************************************************************
  always #50 mclk = ~mclk;
  // cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one bus cycle, checked at t1 and t2, then timed to completion
  task automatic xfer_run(input bus_req_t q, input logic slow);
    int n;
    req <= q;
    req_valid <= 1;
    @(posedge mclk);
    req_valid <= 0;
    #1 chk("addr", q.addr, addr_out_ff);
    chk("mux_lo", {q.addr[7:1], q.xfer[0]}, muxed_addr_data_low_o_ff);
    chk("ube", q.xfer[1], upper_byte_enable_n_ff);
    chk("strobe", 1, addr_strobe_ff);
    @(posedge mclk);
    #1 chk("lo_oe", q.write & !q.xfer[0], muxed_addr_data_low_oe_ff);
    if (q.write & !q.xfer[0]) chk("lo_dat", q.wdata[7:0], muxed_addr_data_low_o_ff);
    chk("hi_adr", q.addr[15:8], muxed_addr_data_high_o_ff);
    chk("dir", q.write, transfer_direction_ff);
    chk("den", 0, transceiver_enable_n_ff);
    chk("wr_n", {!(q.write & !q.xfer[0]), !(q.write & !q.xfer[1])},
      {low_byte_write_n_ff, high_byte_write_n_ff});
    n = 2;
    while (req_done_ff !== 1'b1 && n < 30) begin
      @(posedge mclk);
      #1 n++;
    end
    if (slow) chk("waits", 1, n > 5);
    else chk("lat", 5, n);
    if (!q.write) chk("rdata", rd_val[7:0], rdata_ff[7:0]);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(19884));
    cfg_val = 16'($urandom);
    rd_val = 16'($urandom);
    repeat (6) @(posedge mclk);
    #1 chk("rst_oe", 0, {addr_out_oe_ff, muxed_addr_data_low_oe_ff});
    chk("rst_on", 3'h7, {addr_strobe_oe_ff, sys_clock_out_first_oe_ff, sys_clock_out_second_oe_ff});
    rst_b <= 1;
    repeat (2) @(posedge mclk);
    #1 chk("cfg", cfg_val, reset_cfg_ff);
    chk("stat", 1, status_normal_ff);
    for (int i = 0; i < 8; i++) begin
      r = '0;
      r.addr = 20'($urandom);
      r.xfer = i[1:0];
      r.write = i[2];
      r.kind = i[0] ? KIND_IO : KIND_MEM;
      r.wdata = 16'($urandom);
      rd_val <= 16'($urandom);
      xfer_run(r, 0);
    end
    async_ready_in <= 0;
    repeat (4) @(posedge mclk);
    fork
      xfer_run(r, 1);
      begin
        repeat (5) @(posedge mclk);
        sync_ready_in <= 1;
      end
    join
    dma_request_in <= 2'($urandom);
    repeat (5) @(posedge mclk);
    #1 chk("dma", dma_request_in, dma_req_sync_ff);
    hold_grant <= 1;
    repeat (3) @(posedge mclk);
    #1 chk("hold", 0, {addr_out_oe_ff, muxed_addr_data_low_oe_ff, muxed_addr_data_high_oe_ff,
      upper_byte_enable_oe_ff, transceiver_enable_oe_ff, transfer_direction_oe_ff});
    chk("hold_on", 3'h7, {addr_strobe_oe_ff, sys_clock_out_first_oe_ff, sys_clock_out_second_oe_ff});
    ck = sys_clock_out_first_ff;
    @(posedge mclk);
    #1 chk("clk_full", {2{~ck}}, {sys_clock_out_first_ff, sys_clock_out_second_ff});
    power_save_ctl <= CLK_SEL_SAVE;
    repeat (2) @(posedge mclk);
    #1 ck = sys_clock_out_first_ff;
    repeat (4) @(posedge mclk);
    #1 chk("clk_save", {2{~ck}}, {sys_clock_out_first_ff, sys_clock_out_second_ff});
    all_float_test_mode <= 1;
    power_save_ctl <= CLK_SEL_FLOAT;
    repeat (3) @(posedge mclk);
    #1 chk("float", 0, {addr_strobe_oe_ff, sys_clock_out_first_oe_ff, sys_clock_out_second_oe_ff});
    finish_test();
  end
endmodule
